/* File: include/cip_pkg.sv */
/*
  shared constants of the clocked i/o port: register offsets, command codes,
  fault causes, pin modes and reset values.
  assumes: 32-bit apb with 8-bit byte addresses, one aligned word per register.
*/
package cip_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] CIP_OFF_CMD   = 8'h00; // command word, write only
  localparam logic [7:0] CIP_OFF_DOUT  = 8'h04; // output operation / driven value
  localparam logic [7:0] CIP_OFF_DIN   = 8'h08; // input operation
  localparam logic [7:0] CIP_OFF_STAT  = 8'h0C; // configuration and state
  localparam logic [7:0] CIP_OFF_CAUSE = 8'h10; // last fault cause

  // ==========================================================================
  // command word fields
  localparam int unsigned CIP_OP_LSB   = 0;
  localparam int unsigned CIP_ARG_LSB  = 8;
  localparam int unsigned CIP_INIT_LSB = 16;

  // ==========================================================================
  // command codes
  typedef enum logic [7:0] {
    CIP_OP_ENABLE     = 8'h01,
    CIP_OP_DISABLE    = 8'h02,
    CIP_OP_CFG_IN     = 8'h03,
    CIP_OP_CFG_OUT    = 8'h04,
    CIP_OP_CFG_IN_SS  = 8'h05,
    CIP_OP_CFG_OUT_SS = 8'h06,
    CIP_OP_CLK_OUT    = 8'h07,
    CIP_OP_NO_SDLY    = 8'h08,
    CIP_OP_SDLY       = 8'h09,
    CIP_OP_ATTACH_CLK = 8'h0A,
    CIP_OP_BIND_RDY   = 8'h0B,
    CIP_OP_MODE_DATA  = 8'h0C,
    CIP_OP_MODE_CLK   = 8'h0D,
    CIP_OP_MODE_RDY   = 8'h0E,
    CIP_OP_DRIVE      = 8'h0F,
    CIP_OP_DRIVE_LOW  = 8'h10,
    CIP_OP_PULL_UP    = 8'h11,
    CIP_OP_PULL_DOWN  = 8'h12,
    CIP_OP_PULL_NONE  = 8'h13,
    CIP_OP_SET_ROLE   = 8'h14
  } cip_op_t;

  // role argument of the port control write
  localparam logic [7:0] CIP_ROLE_MASTER_VALUE = 8'h01;

  // ==========================================================================
  // fault causes
  typedef enum logic [2:0] {
    CIP_C_NONE     = 3'h0,
    CIP_C_DISABLED = 3'h1,
    CIP_C_WIDTH    = 3'h2,
    CIP_C_NO_PU    = 3'h3,
    CIP_C_NO_PD    = 3'h4,
    CIP_C_BAD_OP   = 3'h5
  } cip_cause_t;

  // ==========================================================================
  // pin modes
  typedef enum logic [1:0] {
    CIP_PM_DATA  = 2'h0,
    CIP_PM_CLOCK = 2'h1,
    CIP_PM_READY = 2'h2
  } cip_pmode_t;

  // ==========================================================================
  // reset values and counts
  localparam logic      CIP_RST_ENABLED = 1'b0;
  localparam int unsigned CIP_HALF_DIV  = 4;   // ref_clk cycles per port clock half

endpackage : cip_pkg

/* File: src/cip_edge.sv */
/*
  port clock source: internal divider or external clock pin, delivering
  the port clock level and one-cycle rise and fall enables.
  assumes: ext_clk_pin is asynchronous to ref_clk and much slower.
*/
`timescale 1ns/1ps
module cip_edge
  import cip_pkg::*;
#(
  parameter int unsigned HALF_DIV = CIP_HALF_DIV
)(
  input  wire logic ref_clk,     // system clock
  input  wire logic rst_n,       // sync reset, active low
  input  wire logic use_ext,     // 1: take edges from the pin
  input  wire logic ext_clk_pin, // external clock pin
  output logic      port_clk,    // port clock level
  output logic      rise_en,     // one-cycle rising edge pulse
  output logic      fall_en      // one-cycle falling edge pulse
);

  localparam int unsigned CW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(HALF_DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
    logic          sync1;
    logic          sync2;
    logic          prev;
  } cip_edge_st_t;

  cip_edge_st_t s;
  cip_edge_st_t next_s;
  logic         wrap;

  // ==========================================================================
  // divider and pin synchroniser
  always_comb
  begin
    next_s       = s;
    wrap         = (s.cnt == CNT_LAST);
    next_s.cnt   = wrap ? '0 : CW'(s.cnt + 1'b1);
    next_s.lvl   = wrap ? ~s.lvl : s.lvl;
    next_s.sync1 = ext_clk_pin;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // edge pulses; only the second and third stages are looked at
  assign port_clk = use_ext ? s.sync2 : s.lvl;
  assign rise_en  = use_ext ? (s.sync2 & ~s.prev) : (wrap & ~s.lvl);
  assign fall_en  = use_ext ? (~s.sync2 & s.prev) : (wrap & s.lvl);

endmodule : cip_edge

/* File: src/cip_pad.sv */
/*
  pad stage of the port: input synchronisers and the output driver with
  data, clock and ready pin modes, normal and drive-low modes.
  assumes: the bench resolves the wire from pin_out, pin_oe and the device's own value.
*/
`timescale 1ns/1ps
module cip_pad
  import cip_pkg::*;
#(
  parameter int unsigned W = 4
)(
  input  wire logic         ref_clk,     // system clock
  input  wire logic         rst_n,       // sync reset, active low
  input  wire logic         enabled,     // port turned on
  input  wire logic         dir_out,     // port drives its pins
  input  wire logic         drive_low,   // open-drain style drive
  input  wire cip_pmode_t   pmode,       // pin mode
  input  wire logic [W-1:0] out_val,     // data to drive
  input  wire logic         port_clk,    // attached clock level
  input  wire logic         bound_rdy,   // ready-out of the bound port
  input  wire logic [W-1:0] pin_in,      // raw pin levels
  input  wire logic         rdy_pin,     // raw ready-in pin
  output logic [W-1:0]      pin_in_s,    // synchronised pins
  output logic              rdy_in_s,    // synchronised ready-in
  output logic [W-1:0]      pin_out,     // pin output value
  output logic [W-1:0]      pin_oe       // pin output enable
);

  typedef struct packed {
    logic [W-1:0] p1;
    logic [W-1:0] p2;
    logic         r1;
    logic         r2;
  } cip_pad_st_t;

  cip_pad_st_t s;
  cip_pad_st_t next_s;
  logic        drv_bit;
  logic        single;

  // ==========================================================================
  // two-stage synchronisers
  always_comb
  begin
    next_s    = s;
    next_s.p1 = pin_in;
    next_s.p2 = s.p1;
    next_s.r1 = rdy_pin;
    next_s.r2 = s.r1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign pin_in_s = s.p2;
  assign rdy_in_s = s.r2;

  // ==========================================================================
  // driver: clock and ready modes only reach a single-bit port
  assign single  = (pmode != CIP_PM_DATA);
  assign drv_bit = (pmode == CIP_PM_CLOCK) ? port_clk : bound_rdy; // RULE14 RULE15

  always_comb
  begin
    pin_out = '0;
    pin_oe  = '0;
    if (enabled && single)
    begin
      pin_out[0] = drv_bit;
      pin_oe[0]  = 1'b1;
    end
    else if (enabled && dir_out && drive_low)
    begin
      pin_oe = ~out_val; // RULE17
    end
    else if (enabled && dir_out)
    begin
      pin_out = out_val; // RULE13 RULE16
      pin_oe  = '1;
    end
  end

endmodule : cip_pad

/* File: src/cip_port.sv */
/*
  configurable clocked i/o port with apb register access: command decode,
  strobed and plain transfers, direction turnaround, faults.
  assumes: apb master on ref_clk; pins and external clock asynchronous.
*/
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

// What this block does
// [RULE1] ready-in gated output faults if the ready-in source is wider than one bit
// [RULE2] gated output keeps driving the initial value until a new output
// [RULE3] ready-in sampled on sample edge; drive on falling edge after high sample
// [RULE4] input sampled on rising edge, on falling edge with sample delay
// [RULE5] plain input is default; an output switches direction at next fall
// [RULE6] plain output drives at next fall and holds each word one cycle
// [RULE7] an input on an output port turns it round after the held period
// [RULE8] clock output needs a single-bit port, else fault
// [RULE9] the attached clock times both sampling and driving
// [RULE10] binding a ready-out source needs a one-bit port, else fault; the code checks the width in the argument, not the port width W
// [RULE11] enabling sets default state, also when already enabled
// [RULE12] disabling twice does nothing; any use while off faults
// [RULE13] data pin mode is default and outputs set the pins
// [RULE14] clock pin mode drives the clock, single bit only
// [RULE15] ready pin mode drives the bound ready-out, single bit only
// [RULE16] normal drive is default and clears the pulls
// [RULE17] drive-low drives zeros only and enables the variant's pull
// [RULE18] pull-up makes undriven read 1, sets drive-low; faults without pull-ups
// [RULE19] pull-down makes undriven read 0, sets drive-low; faults without pull-downs
// [RULE20] disabling pulls returns to normal drive
// [RULE21] master or slave role set by port control write
// [RULE22] strobed slave input samples only where ready-in is high
// [RULE23] faults give a one-cycle pulse with cause and leave config unchanged
module cip_port
  import cip_pkg::*;
#(
  parameter int unsigned W        = 4,            // port width, 1 to 16
  parameter int unsigned HALF_DIV = CIP_HALF_DIV, // internal port clock divide
  parameter bit          HAS_PU   = 1'b1          // 1: pull-up variant, 0: pull-down
)(
  input  wire logic         ref_clk,     // system clock, 200 MHz
  input  wire logic         rst_n,       // sync reset, active low
  input  wire logic         psel,        // apb select
  input  wire logic         penable,     // apb enable
  input  wire logic         pwrite,      // apb direction
  input  wire logic [7:0]   paddr,       // apb byte address
  input  wire logic [31:0]  pwdata,      // apb write data
  output logic [31:0]       prdata,      // apb read data
  output logic              pready,      // apb ready
  output logic              pslverr,     // apb error
  input  wire logic [W-1:0] pin_in,      // pin levels
  output logic [W-1:0]      pin_out,     // pin drive value
  output logic [W-1:0]      pin_oe,      // pin drive enable
  input  wire logic         rdy_in_pin,  // ready-in pin
  input  wire logic         ext_clk_pin, // external clock pin
  input  wire logic         bound_rdy,   // ready-out of the port bound here
  output logic              ready_out,   // this port's ready-out
  output logic              pull_up,     // pull-up enable
  output logic              pull_down,   // pull-down enable
  output logic              fault,       // one-cycle fault pulse
  output cip_cause_t        fault_cause  // cause of the fault pulse
);

  typedef struct packed {
    logic         enabled;
    logic         dir_out;
    logic         strobed;
    logic         sample_fall;
    logic         clk_ext;
    cip_pmode_t   pmode;
    logic         drive_low;
    logic         pu;
    logic         pd;
    logic         master;
    logic         rdy_bound;
    logic         pend;
    logic         sw_in;
    logic         rdy_seen;
    logic         rdy_out;
    logic [W-1:0] out_val;
    logic [W-1:0] pend_val;
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         flt;
    cip_cause_t   cause;
    cip_cause_t   last_cause;
  } cip_port_st_t;

  localparam cip_port_st_t ST_RST = '{
    enabled: CIP_RST_ENABLED, pmode: CIP_PM_DATA, cause: CIP_C_NONE,
    last_cause: CIP_C_NONE, default: '0};

  cip_port_st_t s;
  cip_port_st_t next_s;
  logic         port_clk;
  logic         rise_en;
  logic         fall_en;
  logic [W-1:0] pin_in_s;
  logic         rdy_in_s;
  logic         acc;
  logic         wr;
  logic         rd;
  logic         sample;
  logic         stall;
  logic         mapped;
  cip_op_t      op;
  logic [7:0]   arg;
  logic [W-1:0] init_val;
  cip_cause_t   fc;

  // ==========================================================================
  // port clock and pads
  cip_edge #(
    .HALF_DIV (HALF_DIV)
  ) u_edge (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .use_ext     (s.clk_ext),
    .ext_clk_pin (ext_clk_pin),
    .port_clk    (port_clk),
    .rise_en     (rise_en),
    .fall_en     (fall_en)
  );

  cip_pad #(
    .W (W)
  ) u_pad (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .enabled   (s.enabled),
    .dir_out   (s.dir_out),
    .drive_low (s.drive_low),
    .pmode     (s.pmode),
    .out_val   (s.out_val),
    .port_clk  (port_clk),
    .bound_rdy (bound_rdy),
    .pin_in    (pin_in),
    .rdy_pin   (rdy_in_pin),
    .pin_in_s  (pin_in_s),
    .rdy_in_s  (rdy_in_s),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe)
  );

  // ==========================================================================
  // apb decode; a second output waits while one is still pending
  assign acc      = psel & penable;
  assign stall    = pwrite & (paddr == CIP_OFF_DOUT) & s.enabled & s.pend;
  assign pready   = ~stall;
  assign wr       = acc & pwrite & pready;
  assign rd       = acc & ~pwrite;
  assign op       = cip_op_t'(pwdata[CIP_OP_LSB +: 8]);
  assign arg      = pwdata[CIP_ARG_LSB +: 8];
  assign init_val = pwdata[CIP_INIT_LSB +: W];
  assign mapped   = (paddr == CIP_OFF_CMD) | (paddr == CIP_OFF_DOUT) | (paddr == CIP_OFF_DIN)
                  | (paddr == CIP_OFF_STAT) | (paddr == CIP_OFF_CAUSE);
  assign sample   = s.sample_fall ? fall_en : rise_en; // RULE4 RULE9

  // ==========================================================================
  // next state: read side effects, port timing, then writes
  always_comb
  begin
    next_s     = s;
    next_s.flt = 1'b0;
    fc         = CIP_C_NONE;
    // input operation: consume data, turn an output port round
    if (rd && paddr == CIP_OFF_DIN)
    begin
      if (!s.enabled)
        fc = CIP_C_DISABLED; // RULE12
      else
      begin
        next_s.in_valid = 1'b0;
        if (s.dir_out || s.pend)
          next_s.sw_in = 1'b1; // RULE7
      end
    end
    if (s.enabled && sample)
    begin
      next_s.rdy_seen = rdy_in_s; // RULE3
      if (!s.dir_out && (!s.strobed || rdy_in_s))
      begin
        next_s.in_data  = pin_in_s; // RULE5 RULE22
        next_s.in_valid = 1'b1;
      end
    end
    if (s.enabled && fall_en)
    begin
      next_s.rdy_out = 1'b0;
      if (s.pend && (!s.strobed || s.rdy_seen))
      begin
        next_s.out_val = s.pend_val; // RULE3 RULE6
        next_s.pend    = 1'b0;
        next_s.dir_out = 1'b1; // RULE5
        next_s.rdy_out = 1'b1;
      end
      else if (s.sw_in && !s.pend)
      begin
        next_s.dir_out = 1'b0; // RULE7
        next_s.sw_in   = 1'b0;
      end
    end
    // output operation
    if (wr && paddr == CIP_OFF_DOUT)
    begin
      if (!s.enabled)
        fc = CIP_C_DISABLED; // RULE12
      else
      begin
        next_s.pend     = 1'b1;
        next_s.pend_val = pwdata[W-1:0];
        next_s.sw_in    = 1'b0;
      end
    end
    // port control write
    if (wr && paddr == CIP_OFF_CMD)
    begin
      if (op == CIP_OP_ENABLE)
      begin
        next_s         = ST_RST; // RULE11
        next_s.enabled = 1'b1;
      end
      else if (op == CIP_OP_DISABLE)
        next_s.enabled = 1'b0; // RULE12
      else if (!s.enabled)
        fc = CIP_C_DISABLED; // RULE12
      else
      begin
        unique case (op)
          CIP_OP_CFG_IN:
          begin
            next_s.dir_out = 1'b0;
            next_s.strobed = 1'b0;
            next_s.pend    = 1'b0;
          end
          CIP_OP_CFG_OUT:
          begin
            next_s.dir_out = 1'b1;
            next_s.strobed = 1'b0;
            next_s.pend    = 1'b0;
            next_s.out_val = init_val;
          end
          CIP_OP_CFG_IN_SS, CIP_OP_CFG_OUT_SS:
          begin
            if (arg > 8'h01)
              fc = CIP_C_WIDTH; // RULE1
            else
            begin
              next_s.dir_out = (op == CIP_OP_CFG_OUT_SS);
              next_s.strobed = 1'b1;
              next_s.pend    = 1'b0;
              next_s.sw_in   = 1'b0;
              if (op == CIP_OP_CFG_OUT_SS)
                next_s.out_val = init_val; // RULE2
            end
          end
          CIP_OP_CLK_OUT, CIP_OP_MODE_CLK:
          begin
            if (W > 1)
              fc = CIP_C_WIDTH; // RULE8 RULE14
            else
              next_s.pmode = CIP_PM_CLOCK;
          end
          CIP_OP_MODE_RDY:
          begin
            if (W > 1)
              fc = CIP_C_WIDTH; // RULE15
            else
              next_s.pmode = CIP_PM_READY;
          end
          CIP_OP_MODE_DATA: next_s.pmode = CIP_PM_DATA; // RULE13
          CIP_OP_NO_SDLY:   next_s.sample_fall = 1'b0; // RULE4
          CIP_OP_SDLY:      next_s.sample_fall = 1'b1;
          CIP_OP_ATTACH_CLK: next_s.clk_ext = arg[0]; // RULE9
          CIP_OP_BIND_RDY:
          begin
            if (arg > 8'h01)
              fc = CIP_C_WIDTH; // RULE10
            else
              next_s.rdy_bound = 1'b1;
          end
          CIP_OP_DRIVE, CIP_OP_PULL_NONE:
          begin
            next_s.drive_low = 1'b0; // RULE16 RULE20
            next_s.pu        = 1'b0;
            next_s.pd        = 1'b0;
          end
          CIP_OP_DRIVE_LOW:
          begin
            next_s.drive_low = 1'b1; // RULE17
            next_s.pu        = HAS_PU;
            next_s.pd        = ~HAS_PU;
          end
          CIP_OP_PULL_UP:
          begin
            if (!HAS_PU)
              fc = CIP_C_NO_PU; // RULE18
            else
            begin
              next_s.pu        = 1'b1;
              next_s.pd        = 1'b0;
              next_s.drive_low = 1'b1;
            end
          end
          CIP_OP_PULL_DOWN:
          begin
            if (HAS_PU)
              fc = CIP_C_NO_PD; // RULE19
            else
            begin
              next_s.pd        = 1'b1;
              next_s.pu        = 1'b0;
              next_s.drive_low = 1'b1;
            end
          end
          CIP_OP_SET_ROLE: next_s.master = (arg == CIP_ROLE_MASTER_VALUE); // RULE21
          default: fc = CIP_C_BAD_OP;
        endcase
      end
    end
    if (fc != CIP_C_NONE)
    begin
      next_s.flt        = 1'b1; // RULE23
      next_s.cause      = fc;
      next_s.last_cause = fc;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s <= ST_RST;
    else
      s <= next_s;
  end

  // ==========================================================================
  // apb read mux and outputs
  always_comb
  begin
    prdata = '0;
    unique case (paddr)
      CIP_OFF_DOUT:  prdata[W-1:0] = s.out_val;
      CIP_OFF_DIN:   prdata[W-1:0] = s.in_data;
      CIP_OFF_STAT:  prdata[15:0]  = {s.in_valid, s.pend, s.sw_in, s.rdy_bound, s.master,
                                      s.pd, s.pu, s.drive_low, s.pmode, s.clk_ext,
                                      s.sample_fall, s.strobed, s.dir_out, s.enabled, 1'b0};
      CIP_OFF_CAUSE: prdata[2:0]   = s.last_cause;
      default:       prdata = '0;
    endcase
  end

  assign pslverr     = acc & pready & (~mapped | (fc != CIP_C_NONE));
  assign ready_out   = s.rdy_out & s.rdy_bound; // RULE10
  assign pull_up     = s.enabled & s.pu; // RULE18
  assign pull_down   = s.enabled & s.pd; // RULE19
  assign fault       = s.flt;
  assign fault_cause = s.cause;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic cmd_wr;
  assign cmd_wr = wr & (paddr == CIP_OFF_CMD);

  property p_rdyin_width;
    cmd_wr && s.enabled && op == CIP_OP_CFG_OUT_SS && arg > 8'h01
      |=> fault && fault_cause == CIP_C_WIDTH && $stable(s.strobed);
  endproperty
  a_rdyin_width: assert property (p_rdyin_width) else $error("ready-in width fault missing"); // RULE1

  property p_gate_hold;
    s.enabled && fall_en && s.strobed && !s.rdy_seen && !cmd_wr |=> $stable(s.out_val);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("output moved without ready-in"); // RULE3

  property p_plain_drive;
    s.enabled && fall_en && s.pend && !s.strobed && !cmd_wr
      |=> s.out_val == $past(s.pend_val) && s.dir_out && !s.pend;
  endproperty
  a_plain_drive: assert property (p_plain_drive) else $error("output not driven at fall"); // RULE6

  property p_turn_in;
    s.enabled && fall_en && s.sw_in && !s.pend && !cmd_wr && !wr |=> !s.dir_out;
  endproperty
  a_turn_in: assert property (p_turn_in) else $error("port did not turn to input"); // RULE7

  property p_enable_default;
    cmd_wr && op == CIP_OP_ENABLE
      |=> s.enabled && !s.dir_out && s.pmode == CIP_PM_DATA && !s.drive_low && !s.pend;
  endproperty
  a_enable_default: assert property (p_enable_default) else $error("enable not default"); // RULE11

  property p_off_fault;
    !s.enabled && wr && paddr == CIP_OFF_DOUT |=> fault ##1 !fault;
  endproperty
  a_off_fault: assert property (p_off_fault) else $error("use while off not faulted"); // RULE12

  property p_pull_none;
    cmd_wr && s.enabled && op == CIP_OP_PULL_NONE |=> !s.drive_low && !pull_up && !pull_down;
  endproperty
  a_pull_none: assert property (p_pull_none) else $error("pull none left pulls on"); // RULE20

  property p_strobe_in;
    s.enabled && sample && !s.dir_out && s.strobed && !rdy_in_s |=> $stable(s.in_data);
  endproperty
  a_strobe_in: assert property (p_strobe_in) else $error("sampled without ready-in"); // RULE22

  property p_clk_width;
    cmd_wr && s.enabled && op == CIP_OP_MODE_CLK && W > 1
      |=> fault && s.pmode == $past(s.pmode);
  endproperty
  a_clk_width: assert property (p_clk_width) else $error("wide clock mode accepted"); // RULE14

  c_out: cover property (s.enabled && fall_en && s.pend ##1 s.dir_out);
  c_turn: cover property (s.sw_in ##[1:200] !s.dir_out);
  c_fault: cover property (fault && fault_cause == CIP_C_WIDTH);

endmodule : cip_port

/* File: verif/cip_ext_dev.sv */
/*
  external device on the port pins: drives its own value where the port
  does not, raises ready-in while it accepts and keeps the external clock still.
  assumes: pins come as separate value and enable vectors.
*/
`timescale 1ns/1ps
module cip_ext_dev #(
  parameter int unsigned W = 4
)(
  input  wire logic [W-1:0] pin_out,  // port drive value
  input  wire logic [W-1:0] pin_oe,   // port drive enable
  input  wire logic [W-1:0] ext_val,  // value this device drives
  input  wire logic         accept,   // 1: ready to take or give data
  output logic [W-1:0]      wire_lvl, // resolved pin level
  output logic              rdy_in,   // ready-in to the port
  output logic              ext_clk   // external clock, idle low
);
  // ==========
  // pin resolution, the port wins where it drives
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      wire_lvl[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
    end
  end
  assign rdy_in  = accept;
  assign ext_clk = 1'b0; // no frames on the clock pin
endmodule : cip_ext_dev

/* File: verif/testbench.sv */
/*
  bench top: apb tasks and command sequences for the port.
  assumes: 4-bit pull-up variant with a fast internal port clock.
*/
`timescale 1ns/1ps
module testbench import cip_pkg::*;;
  localparam int unsigned HD = 2;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, fault, rdy, eclk;
  logic        acc_en, pu, pd, rdy_o;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ext_val, pin_lvl, pin_out, pin_oe;
  cip_cause_t  fault_cause;
  int          miscompares, num_checks, i;
  logic [31:0] bad_w [7] = '{32'h0407, 32'h040D, 32'h040E, 32'h040B, 32'h0406, 32'h12, 32'hFF};
  logic [2:0]  bad_c [7] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h5};
  logic [31:0] ok_w [9]  = '{32'h11, 32'h13, 32'h10, 32'h0F, 32'h09, 32'h0114, 32'h010B,
                             32'h010A, 32'h000A};
  logic [31:0] ok_s [9]  = '{32'h0302, 32'h0002, 32'h0302, 32'h0002, 32'h0012, 32'h0812,
                             32'h1812, 32'h1832, 32'h1812};

  cip_port #(.W(4), .HALF_DIV(HD), .HAS_PU(1'b1)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_lvl),
    .pin_out(pin_out), .pin_oe(pin_oe), .rdy_in_pin(rdy), .ext_clk_pin(eclk),
    .bound_rdy(rdy_o), .ready_out(rdy_o), .pull_up(pu), .pull_down(pd), .fault(fault),
    .fault_cause(fault_cause));
  cip_ext_dev #(.W(4)) ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .accept(acc_en), .wire_lvl(pin_lvl), .rdy_in(rdy), .ext_clk(eclk));

  // ==========
  // clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========
  // compare, apb transfer, fault and pin waits
  task automatic chk(string nm, logic [31:0] e, s);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic err, logic [31:0] e, m);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      miscompares++;
      report_and_stop();
    end
    chk("pslverr", err, pslverr);
    if (!wr && m != 0)
      chk("prdata", e, prdata & m);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic flt(logic [2:0] c);
    @(posedge ref_clk);
    chk("fault", 1, fault);
    chk("fault_cause", c, fault_cause);
  endtask : flt

  task automatic wait_pins(logic [3:0] oe, lvl);
    int n;
    n = 0;
    while ((pin_oe !== oe || pin_lvl !== lvl) && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("pins", {oe, lvl}, {pin_oe, pin_lvl});
    if (n >= 200)
      report_and_stop();
  endtask : wait_pins

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ==========
  // main sequence
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    ext_val = 4'h5;
    acc_en = 1'b1;
    miscompares = 0;
    num_checks = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b1, CIP_OFF_DOUT, 32'h3, 1'b1, 0, 0);
    flt(CIP_C_DISABLED);
    apb(1'b1, CIP_OFF_CMD, 32'h02, 1'b0, 0, 0);
    apb(1'b1, CIP_OFF_CMD, 32'h01, 1'b0, 0, 0);
    apb(1'b0, CIP_OFF_STAT, 0, 1'b0, 32'h0002, 32'h7FFF);
    for (i = 0; i < 7; i++)
    begin
      apb(1'b1, CIP_OFF_CMD, bad_w[i], 1'b1, 0, 0);
      flt(bad_c[i]);
    end
    apb(1'b0, CIP_OFF_STAT, 0, 1'b0, 32'h0002, 32'h7FFF);
    for (i = 0; i < 9; i++)
    begin
      apb(1'b1, CIP_OFF_CMD, ok_w[i], 1'b0, 0, 0);
      apb(1'b0, CIP_OFF_STAT, 0, 1'b0, ok_s[i], 32'h7FFF);
      chk("pulls", ok_s[i][10:9], {pd, pu});
    end
    apb(1'b1, CIP_OFF_CMD, 32'h0006_0004, 1'b0, 0, 0);
    wait_pins(4'hF, 4'h6);
    apb(1'b1, CIP_OFF_DOUT, 32'hA, 1'b0, 0, 0);
    apb(1'b1, CIP_OFF_DOUT, 32'h3, 1'b0, 0, 0);
    wait_pins(4'hF, 4'h3);
    chk("ready_out", 1, rdy_o);
    apb(1'b0, CIP_OFF_DIN, 0, 1'b0, 0, 0);
    wait_pins(4'h0, 4'h5);
    chk("ready_out", 0, rdy_o);
    repeat (4 * HD + 4) @(posedge ref_clk);
    apb(1'b0, CIP_OFF_DIN, 0, 1'b0, 32'h5, 32'hF);
    // gated output: held at the initial value until ready-in is seen high
    acc_en <= 1'b0;
    apb(1'b1, CIP_OFF_CMD, 32'h0009_0106, 1'b0, 0, 0);
    wait_pins(4'hF, 4'h9);
    repeat (4 * HD) @(posedge ref_clk);
    apb(1'b1, CIP_OFF_DOUT, 32'h4, 1'b0, 0, 0);
    repeat (4 * HD + 4) @(posedge ref_clk);
    wait_pins(4'hF, 4'h9);
    acc_en <= 1'b1;
    wait_pins(4'hF, 4'h4);
    // strobed input: pins taken only while ready-in is high
    acc_en <= 1'b0;
    ext_val <= 4'hC;
    apb(1'b1, CIP_OFF_CMD, 32'h0105, 1'b0, 0, 0);
    repeat (4 * HD + 4) @(posedge ref_clk);
    apb(1'b0, CIP_OFF_DIN, 0, 1'b0, 32'h5, 32'hF);
    acc_en <= 1'b1;
    repeat (4 * HD + 4) @(posedge ref_clk);
    apb(1'b0, CIP_OFF_DIN, 0, 1'b0, 32'hC, 32'hF);
    report_and_stop();
  end
endmodule : testbench
